// File: include/cgu_pkg.sv
// Constants, register map and field layout of the clock generation unit
package cgu_pkg;
    localparam int NUM_GROUPS = 11;
    localparam int NUM_FUNCS = 16;
    localparam int NUM_SRCS = 4;
    localparam int NUM_DIVS = 9;
    localparam int SINGLE_DIV_GROUPS = 3;
    localparam int MULTI_DIV_LAST = 5;
    localparam int DIVS_PER_MULTI = 2;
    localparam int SEL_W = 2;
    localparam int FRAC_W = 16;

    // Register byte offsets
    localparam logic [7:0] SRC_SEL = 8'h00;
    localparam logic [7:0] LP_PLL = 8'h04;
    localparam logic [7:0] HS_PLL = 8'h08;
    localparam logic [7:0] FUNC_EN = 8'h0C;
    localparam logic [7:0] FUNC_EVT = 8'h10;
    localparam logic [7:0] FUNC_DSEL = 8'h14;
    localparam logic [7:0] SOFT_RST = 8'h18;
    localparam logic [7:0] WDT_CTRL = 8'h1C;
    localparam logic [7:0] WDT_LOAD = 8'h20;
    localparam logic [7:0] WDT_FEED = 8'h24;
    localparam logic [7:0] STATUS = 8'h28;
    localparam logic [7:0] DIV_BASE = 8'h40;

    // PLL reference encodings
    localparam logic [2:0] REF_MAIN_OSC = 3'h0;
    localparam logic [2:0] REF_LAST = 3'h5;

    // Field positions
    localparam int LP_REF_LSB = 0;
    localparam int LP_MUL_LSB = 3;
    localparam int LP_POST_LSB = 8;
    localparam int HS_REF_LSB = 0;
    localparam int HS_PRE_LSB = 3;
    localparam int HS_MUL_LSB = 11;
    localparam int HS_POST_LSB = 21;
    localparam int WDT_RST_EN = 0;
    localparam int WDT_IRQ_EN = 1;
    localparam int ST_WDT_CAUSE = 0;
    localparam int ST_WDT_IRQ = 1;
    localparam int DIV_MOD_LSB = 16;

    // Reset values and timing
    localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
    localparam logic [31:0] WDT_LOAD_RST = 32'h0000_FFFF;
    localparam logic [4:0] CHIP_RST_HOLD = 5'h10;
    localparam int CLK_MHZ = 250;
    localparam int PIN_HOLD_US = 1000;
    localparam int PIN_HOLD_CYC = PIN_HOLD_US * CLK_MHZ;

    // Clock group that feeds each function
    function automatic int func_group(input int f);
        return (f < NUM_GROUPS) ? f : f - 8;
    endfunction : func_group
endpackage : cgu_pkg

// File: tb/reset_event_source.sv
// Outside reset source and event router levels seen by the unit
module reset_event_source #(
    parameter int HOLD_CYC = 40
) (
    input wire logic clk,
    input wire logic pin_req,
    input wire logic [cgu_pkg::NUM_FUNCS-1:0] evt_req,
    output logic rst_pin_n,
    output logic [cgu_pkg::NUM_FUNCS-1:0] evt_clk_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // Hold count shortened from the power-up figure to keep runs short
    int hold_q = HOLD_CYC;

    // Pin held low from power-up and after each request
    always @(posedge clk) begin
        if (pin_req) begin
            hold_q <= HOLD_CYC;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end
    end
    assign rst_pin_n = (hold_q == 0);

    // Router levels change just after an edge
    always @(posedge clk) begin
        evt_clk_on <= evt_req;
    end
endmodule : reset_event_source

// File: tb/test_clock_reset_generation_unit.sv
// Self-checking bench of the clock generation unit
`define CHECK(nm, ex, gt) \
    begin \
        total_checks++; \
        if ((gt) !== (ex)) begin \
            n_errors++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
        end \
    end
module test_clock_reset_generation_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, boot_addr, rv;
    logic rst_pin_n, chip_rst, wdt_irq;
    logic pin_req = 1'b0;
    logic clr = 1'b1;
    logic [3:0] src_tick = 4'h0;
    logic [15:0] evt_req = 16'h0000;
    logic [15:0] evt_clk_on, func_tick, soft_rst;
    logic [2:0] lp_ref_sel, hs_ref_sel;
    logic [5:0] lp_mult;
    logic [3:0] lp_postdiv;
    logic [8:0] hs_prediv;
    logic [10:0] hs_mult;
    logic [4:0] hs_postdiv;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n, src_cnt[4], ft_cnt[16], inc[5], md[5];
    bit ok;

    clock_gen_unit i_clock_gen_unit (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rst_pin_n(rst_pin_n), .src_tick(src_tick),
        .evt_clk_on(evt_clk_on), .func_tick(func_tick),
        .soft_rst(soft_rst), .chip_rst(chip_rst), .boot_addr(boot_addr),
        .wdt_irq(wdt_irq), .lp_ref_sel(lp_ref_sel), .lp_mult(lp_mult),
        .lp_postdiv(lp_postdiv), .hs_ref_sel(hs_ref_sel),
        .hs_prediv(hs_prediv), .hs_mult(hs_mult), .hs_postdiv(hs_postdiv));
    reset_event_source i_reset_event_source (.clk(clk), .pin_req(pin_req),
        .evt_req(evt_req), .rst_pin_n(rst_pin_n), .evt_clk_on(evt_clk_on));

    // Clock, random source pulses never two in a row, pulse counters
    always #2 clk = ~clk;
    always @(posedge clk) begin
        src_tick <= 4'($urandom) & ~src_tick;
        for (int i = 0; i < 16; i++) begin
            ft_cnt[i] <= clr ? 0 : ft_cnt[i] + int'(func_tick[i]);
            if (i < 4) begin
                src_cnt[i] <= clr ? 0 : src_cnt[i] + int'(src_tick[i]);
            end
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    function automatic int exp_div(int cnt, int i, int m);
        return (m == 0 || i >= m) ? cnt : cnt * i / m;
    endfunction : exp_div

    function automatic bit near(int a, int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction : near

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        `CHECK("reg_read", ex, rdata)
        @(posedge clk);
        `CHECK("rdata_idle", 32'h0000_0000, rdata)
    endtask : chk_rd

    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) begin
            @(posedge clk);
        end
    endtask : wait_lvl

    // Settle, then count pulses over a fixed window
    task automatic measure();
        repeat (40) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (300) @(posedge clk);
    endtask : measure

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        rv = $urandom(32'h7867);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wait_lvl(rst_pin_n, 1'b1, 200);
        repeat (8) @(posedge clk);
        wait_lvl(chip_rst, 1'b0, 50);
        `CHECK("chip_rst_rel", 1'b0, chip_rst)
        `CHECK("boot_addr", 32'h0000_0000, boot_addr)
        `CHECK("pll_dflt", 35'h0_2201_0021, {lp_mult, lp_postdiv, hs_prediv, hs_mult, hs_postdiv})
        wr_reg(8'h3C, 32'hFFFF_FFFF);
        for (int a = 0; a <= 8'h60; a += 4) begin
            rv = (a == 8'h20 || a == 8'h24) ? 32'h0000_FFFF : 32'h0000_0000;
            chk_rd(8'(a), rv);
        end
        // Enable, event, divider select and block reset registers
        for (int j = 0; j < 4; j++) begin
            rv = 32'($urandom) & 32'h0000_FFFF;
            wr_reg(cgu_pkg::FUNC_EN + 8'(4 * j), rv);
            chk_rd(cgu_pkg::FUNC_EN + 8'(4 * j), rv);
            if (j == 3) `CHECK("soft_rst", rv[15:0], soft_rst)
            wr_reg(cgu_pkg::FUNC_EN + 8'(4 * j), 32'h0000_0000);
        end
        // Every reference code with field corners
        for (int r = 0; r < 8; r++) begin
            rv = (r == 0) ? 32'h0 : (r == 7) ? 32'hFFFF_FFFF : 32'($urandom);
            wr_reg(cgu_pkg::LP_PLL, {22'h00_0000, rv[9:3], 3'(r)});
            wr_reg(cgu_pkg::HS_PLL, {7'h00, rv[24:3], 3'(r)});
            @(posedge clk);
            `CHECK("lp_ref", (r < 6) ? 3'(r) : 3'h0, lp_ref_sel)
            `CHECK("hs_ref", (r < 6) ? 3'(r) : 3'h0, hs_ref_sel)
            `CHECK("lp_mult", 6'(rv[7:3]) + 6'h01, lp_mult)
            `CHECK("lp_post", 4'h1 << rv[9:8], lp_postdiv)
            `CHECK("hs_pre", 9'(rv[10:3]) + 9'h001, hs_prediv)
            `CHECK("hs_mul", 11'(rv[20:11]) + 11'h001, hs_mult)
            `CHECK("hs_post", 5'(rv[24:21]) + 5'h01, hs_postdiv)
        end
        // Source switching of an undivided group
        wr_reg(cgu_pkg::FUNC_EN, 32'h0000_00C0);
        for (int s = 0; s < 4; s++) begin
            wr_reg(cgu_pkg::SRC_SEL, 32'(s) << 12);
            measure();
            `CHECK("grp_src", src_cnt[s], ft_cnt[6])
            `CHECK("other_fn", src_cnt[0], ft_cnt[7])
        end
        wr_reg(cgu_pkg::FUNC_EVT, 32'h0000_0040);
        for (int e = 0; e < 2; e++) begin
            evt_req <= 16'(e) << 6;
            measure();
            `CHECK("evt_gate", e ? src_cnt[3] : 0, ft_cnt[6])
        end
        wr_reg(cgu_pkg::FUNC_EN, 32'h0000_0080);
        measure();
        `CHECK("fn_off", 0, ft_cnt[6])
        `CHECK("fn_kept", src_cnt[0], ft_cnt[7])
        // Fractional dividers, one with a zero modulus
        wr_reg(cgu_pkg::FUNC_EN, 32'h0000_0807);
        for (int d = 0; d < 5; d++) begin
            inc[d] = $urandom_range(6, 1);
            md[d] = (d == 2) ? 0 : $urandom_range(12, 2);
            wr_reg(cgu_pkg::DIV_BASE + 8'(4 * d), {16'(md[d]), 16'(inc[d])});
        end
        for (int k = 0; k < 2; k++) begin
            wr_reg(cgu_pkg::FUNC_DSEL, 32'(k) << 11);
            measure();
            for (int d = 0; d < 3; d++) begin
                ok = near(ft_cnt[d], exp_div(src_cnt[0], inc[d], md[d]));
                `CHECK("single_div", 1'b1, ok)
            end
            ok = near(ft_cnt[11], exp_div(src_cnt[0], inc[3 + k], md[3 + k]));
            `CHECK("multi_div", 1'b1, ok)
        end
        // Watchdog as interrupt only, fed then starved
        wr_reg(cgu_pkg::WDT_LOAD, 32'h0000_0040);
        wr_reg(cgu_pkg::WDT_FEED, 32'h0000_0000);
        wr_reg(cgu_pkg::WDT_CTRL, 32'h0000_0002);
        repeat (3) begin
            repeat (40) @(posedge clk);
            wr_reg(cgu_pkg::WDT_FEED, 32'h0000_0000);
        end
        `CHECK("wdt_fed", 1'b0, wdt_irq)
        wait_lvl(wdt_irq, 1'b1, 100);
        `CHECK("wdt_irq", 2'h2, {wdt_irq, chip_rst})
        wr_reg(cgu_pkg::WDT_CTRL, 32'h0000_0000);
        chk_rd(cgu_pkg::STATUS, 32'h0000_0002);
        wr_reg(cgu_pkg::STATUS, 32'h0000_0002);
        @(posedge clk);
        `CHECK("irq_clr", 1'b0, wdt_irq)
        // Watchdog as chip reset
        wr_reg(cgu_pkg::WDT_FEED, 32'h0000_0000);
        wr_reg(cgu_pkg::WDT_CTRL, 32'h0000_0001);
        wait_lvl(chip_rst, 1'b1, 100);
        n = 0;
        while (chip_rst === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        `CHECK("wdt_hold", int'(cgu_pkg::CHIP_RST_HOLD), n)
        chk_rd(cgu_pkg::STATUS, 32'h0000_0001);
        chk_rd(cgu_pkg::FUNC_EN, 32'h0000_0000);
        chk_rd(cgu_pkg::WDT_LOAD, 32'h0000_FFFF);
        // External pin reset clears the watchdog cause
        pin_req <= 1'b1;
        @(posedge clk);
        pin_req <= 1'b0;
        wait_lvl(chip_rst, 1'b1, 8);
        `CHECK("pin_reset", 1'b1, chip_rst)
        wait_lvl(chip_rst, 1'b0, 100);
        @(posedge clk);
        chk_rd(cgu_pkg::STATUS, 32'h0000_0000);
        test_done();
    end
endmodule : test_clock_reset_generation_unit

// File: verilog/clk_gate_cell.sv
// Per-function clock gate that only changes state on a clock pulse
module clk_gate_cell (
    input wire logic clk,
    input wire logic rst,
    input wire logic src_tick,
    input wire logic en_req,
    output logic out_tick
);
    logic en_q;
    logic en_d;

    // Enable sampled only at a pulse boundary
    always_comb begin
        en_d = src_tick ? en_req : en_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= 1'b0;
        end else begin
            en_q <= en_d;
        end
    end

    // Whole pulses pass or none
    assign out_tick = src_tick & en_q;
endmodule : clk_gate_cell

// File: verilog/clock_gen_unit.sv
// Clock generation and reset unit: top level
// What this block does
// - The reset pin and the watchdog are the only chip resets.
// - At reset release all registers but the watchdog cause flag are at reset values, boot at 0.
// - An unserviced watchdog causes a full chip reset.
// - Software can read whether the last reset came from the watchdog.
// - Watchdog expiry can raise an interrupt, with or without reset.
// - Register bits reset individual blocks without a chip reset.
// - Each PLL picks its reference from six possible sources.
// - Low-power PLL multiplies by 1 to 32 then divides by 1,2,4,8.
// - High-speed PLL prediv 1-256, mult 1-1024, postdiv 1-16.
// - Eleven groups select a source clock without glitches.
// - Three groups own one fractional divider each.
// - Three groups own several dividers, chosen per function.
// - Each function has its own clock enable.
// - An event signal can switch a function clock on and off.
// - A register read completes in two bus cycles, a write in one.
//
// Local design decisions: the plain strobed port and the register offsets.
module clock_gen_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic rst_pin_n,
    input wire logic [cgu_pkg::NUM_SRCS-1:0] src_tick,
    input wire logic [cgu_pkg::NUM_FUNCS-1:0] evt_clk_on,
    output logic [cgu_pkg::NUM_FUNCS-1:0] func_tick,
    output logic [cgu_pkg::NUM_FUNCS-1:0] soft_rst,
    output logic chip_rst,
    output logic [31:0] boot_addr,
    output logic wdt_irq,
    output logic [2:0] lp_ref_sel,
    output logic [5:0] lp_mult,
    output logic [3:0] lp_postdiv,
    output logic [2:0] hs_ref_sel,
    output logic [8:0] hs_prediv,
    output logic [10:0] hs_mult,
    output logic [4:0] hs_postdiv
);
    localparam int NG = cgu_pkg::NUM_GROUPS;
    localparam int NF = cgu_pkg::NUM_FUNCS;
    localparam int ND = cgu_pkg::NUM_DIVS;
    localparam int SW = cgu_pkg::SEL_W;

    logic [NG*SW-1:0] src_sel_q, src_sel_d;
    logic [9:0] lp_q, lp_d;
    logic [24:0] hs_q, hs_d;
    logic [NF-1:0] fen_q, fen_d, fevt_q, fevt_d, fdsel_q, fdsel_d;
    logic [NF-1:0] srst_q, srst_d;
    logic [1:0] wctl_q, wctl_d;
    logic [31:0] wload_q, wload_d, wcnt_q, wcnt_d;
    logic [31:0] div_q [ND];
    logic [31:0] div_d [ND];
    logic [31:0] rdata_q, rdata_d;
    logic s1_q, s2_q, s3_q, pin_low_q, pin_low_d;
    logic [4:0] hold_q, hold_d;
    logic cause_q, cause_d, irq_q, irq_d, chip_rst_q, chip_rst_d;
    logic sys_rst, wdt_expire, wdt_fire;
    logic [NG-1:0] grp_tick;
    logic [ND-1:0] div_tick;

    // Configuration registers reset on power-on or chip reset
    assign sys_rst = rst | chip_rst_q;

    // Register writes
    always_comb begin
        src_sel_d = src_sel_q;
        lp_d = lp_q;
        hs_d = hs_q;
        fen_d = fen_q;
        fevt_d = fevt_q;
        fdsel_d = fdsel_q;
        srst_d = srst_q;
        wctl_d = wctl_q;
        wload_d = wload_q;
        for (int i = 0; i < ND; i++) begin
            div_d[i] = div_q[i];
            if (wr && addr == cgu_pkg::DIV_BASE + 8'(4 * i)) begin
                div_d[i] = wdata;
            end
        end
        if (wr) begin
            case (addr)
                cgu_pkg::SRC_SEL: src_sel_d = wdata[NG*SW-1:0];
                cgu_pkg::LP_PLL: lp_d = wdata[9:0];
                cgu_pkg::HS_PLL: hs_d = wdata[24:0];
                cgu_pkg::FUNC_EN: fen_d = wdata[NF-1:0];
                cgu_pkg::FUNC_EVT: fevt_d = wdata[NF-1:0];
                cgu_pkg::FUNC_DSEL: fdsel_d = wdata[NF-1:0];
                cgu_pkg::SOFT_RST: srst_d = wdata[NF-1:0];
                cgu_pkg::WDT_CTRL: wctl_d = wdata[1:0];
                cgu_pkg::WDT_LOAD: wload_d = wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_sel_q <= '0;
            lp_q <= '0;
            hs_q <= '0;
            fen_q <= '0;
            fevt_q <= '0;
            fdsel_q <= '0;
            srst_q <= '0;
            wctl_q <= '0;
            wload_q <= cgu_pkg::WDT_LOAD_RST;
            for (int i = 0; i < ND; i++) begin
                div_q[i] <= '0;
            end
        end else begin
            src_sel_q <= src_sel_d;
            lp_q <= lp_d;
            hs_q <= hs_d;
            fen_q <= fen_d;
            fevt_q <= fevt_d;
            fdsel_q <= fdsel_d;
            srst_q <= srst_d;
            wctl_q <= wctl_d;
            wload_q <= wload_d;
            for (int i = 0; i < ND; i++) begin
                div_q[i] <= div_d[i];
            end
        end
    end

    // Watchdog down-counter; feed write reloads
    always_comb begin
        wcnt_d = wcnt_q;
        wdt_expire = 1'b0;
        if (wr && addr == cgu_pkg::WDT_FEED) begin
            wcnt_d = wload_q;
        end else if (|wctl_q) begin
            if (wcnt_q == '0) begin
                wdt_expire = 1'b1;
                wcnt_d = wload_q;
            end else begin
                wcnt_d = wcnt_q - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wcnt_q <= cgu_pkg::WDT_LOAD_RST;
        end else begin
            wcnt_q <= wcnt_d;
        end
    end

    assign wdt_fire = wdt_expire & wctl_q[cgu_pkg::WDT_RST_EN];

    // Reset pin filter, chip reset hold, cause and interrupt flags
    always_comb begin
        pin_low_d = pin_low_q;
        if (s2_q == s3_q) begin
            pin_low_d = ~s3_q;
        end
        hold_d = hold_q;
        if (wdt_fire) begin
            hold_d = cgu_pkg::CHIP_RST_HOLD;
        end else if (hold_q != '0) begin
            hold_d = hold_q - 5'h01;
        end
        chip_rst_d = pin_low_d | (hold_d != '0);
        cause_d = cause_q;
        if (pin_low_q) begin
            cause_d = 1'b0;
        end else if (wdt_fire) begin
            cause_d = 1'b1;
        end
        irq_d = irq_q;
        if (chip_rst_q) begin
            irq_d = 1'b0;
        end else if (wdt_expire && wctl_q[cgu_pkg::WDT_IRQ_EN]) begin
            irq_d = 1'b1; // Set wins over the STATUS write clear, chip reset clear wins over set
        end else if (wr && addr == cgu_pkg::STATUS
                     && wdata[cgu_pkg::ST_WDT_IRQ]) begin
            irq_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            pin_low_q <= 1'b0;
            hold_q <= '0;
            chip_rst_q <= 1'b0;
            cause_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            s1_q <= rst_pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_low_q <= pin_low_d;
            hold_q <= hold_d;
            chip_rst_q <= chip_rst_d;
            cause_q <= cause_d;
            irq_q <= irq_d;
        end
    end

    // Register read, data in the following cycle
    always_comb begin
        rdata_d = '0;
        if (rd) begin
            case (addr)
                cgu_pkg::SRC_SEL: rdata_d = 32'(src_sel_q);
                cgu_pkg::LP_PLL: rdata_d = 32'(lp_q);
                cgu_pkg::HS_PLL: rdata_d = 32'(hs_q);
                cgu_pkg::FUNC_EN: rdata_d = 32'(fen_q);
                cgu_pkg::FUNC_EVT: rdata_d = 32'(fevt_q);
                cgu_pkg::FUNC_DSEL: rdata_d = 32'(fdsel_q);
                cgu_pkg::SOFT_RST: rdata_d = 32'(srst_q);
                cgu_pkg::WDT_CTRL: rdata_d = 32'(wctl_q);
                cgu_pkg::WDT_LOAD: rdata_d = wload_q;
                cgu_pkg::WDT_FEED: rdata_d = wcnt_q;
                cgu_pkg::STATUS: rdata_d = 32'({irq_q, cause_q});
                default: ;
            endcase
            for (int i = 0; i < ND; i++) begin
                if (addr == cgu_pkg::DIV_BASE + 8'(4 * i)) begin
                    rdata_d = div_q[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Glitch-free source switch per group
    for (genvar g = 0; g < NG; g++) begin : g_grp
        logic [SW-1:0] act_q, act_d, want;
        logic sw_q, sw_d;
        always_comb begin
            want = src_sel_q[g*SW +: SW];
            act_d = act_q;
            sw_d = sw_q;
            if (sw_q && src_tick[want]) begin
                act_d = want;
                sw_d = 1'b0;
            end else if (!sw_q && want != act_q && src_tick[act_q]) begin
                sw_d = 1'b1;
            end
        end
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                act_q <= '0;
                sw_q <= 1'b0;
            end else begin
                act_q <= act_d;
                sw_q <= sw_d;
            end
        end
        assign grp_tick[g] = src_tick[act_q] & ~sw_q;
    end

    // Fractional dividers: three single, three groups of two
    for (genvar d = 0; d < ND; d++) begin : g_div
        localparam int G = (d < cgu_pkg::SINGLE_DIV_GROUPS) ? d :
            cgu_pkg::SINGLE_DIV_GROUPS
            + (d - cgu_pkg::SINGLE_DIV_GROUPS) / cgu_pkg::DIVS_PER_MULTI;
        frac_div u_div (
            .clk(clk),
            .rst(sys_rst),
            .src_tick(grp_tick[G]),
            .inc(div_q[d][cgu_pkg::FRAC_W-1:0]),
            .mod(div_q[d][cgu_pkg::DIV_MOD_LSB +: cgu_pkg::FRAC_W]),
            .out_tick(div_tick[d])
        );
    end

    // Per-function clock choice and gate
    for (genvar f = 0; f < NF; f++) begin : g_fn
        localparam int G = cgu_pkg::func_group(f);
        localparam int MB = cgu_pkg::SINGLE_DIV_GROUPS
            + (G - cgu_pkg::SINGLE_DIV_GROUPS) * cgu_pkg::DIVS_PER_MULTI;
        logic src;
        if (G < cgu_pkg::SINGLE_DIV_GROUPS) begin : g_one
            assign src = div_tick[G];
        end else if (G <= cgu_pkg::MULTI_DIV_LAST) begin : g_many
            assign src = fdsel_q[f] ? div_tick[MB + 1] : div_tick[MB];
        end else begin : g_none
            assign src = grp_tick[G];
        end
        clk_gate_cell u_gate (
            .clk(clk),
            .rst(sys_rst),
            .src_tick(src),
            .en_req(fen_q[f] & (~fevt_q[f] | evt_clk_on[f])),
            .out_tick(func_tick[f])
        );
    end

    // PLL settings, stored as factor minus one except the low-power postdiv, stored as its log2
    always_comb begin
        lp_ref_sel = lp_q[cgu_pkg::LP_REF_LSB +: 3];
        if (lp_ref_sel > cgu_pkg::REF_LAST) begin
            lp_ref_sel = cgu_pkg::REF_MAIN_OSC;
        end
        hs_ref_sel = hs_q[cgu_pkg::HS_REF_LSB +: 3];
        if (hs_ref_sel > cgu_pkg::REF_LAST) begin
            hs_ref_sel = cgu_pkg::REF_MAIN_OSC;
        end
        lp_mult = {1'b0, lp_q[cgu_pkg::LP_MUL_LSB +: 5]} + 6'h01;
        lp_postdiv = 4'h1 << lp_q[cgu_pkg::LP_POST_LSB +: 2];
        hs_prediv = {1'b0, hs_q[cgu_pkg::HS_PRE_LSB +: 8]} + 9'h001;
        hs_mult = {1'b0, hs_q[cgu_pkg::HS_MUL_LSB +: 10]} + 11'h001;
        hs_postdiv = {1'b0, hs_q[cgu_pkg::HS_POST_LSB +: 4]} + 5'h01;
    end

    assign rdata = rdata_q;
    assign soft_rst = srst_q;
    assign chip_rst = chip_rst_q;
    assign wdt_irq = irq_q;
    assign boot_addr = cgu_pkg::RESET_VECTOR;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pin_resets_chip: assert property (pin_low_q |-> chip_rst)
        else $error("pin reset did not reset chip");
    a_wdt_resets_chip: assert property (wdt_fire |=> chip_rst && cause_q)
        else $error("watchdog expiry did not reset chip");
    a_cause_readable: assert property (rd && addr == cgu_pkg::STATUS |=> rdata[0] == $past(cause_q))
        else $error("reset cause not readable");
    a_wdt_irq_set: assert property (wdt_expire && wctl_q[1] && !chip_rst |=> wdt_irq)
        else $error("watchdog interrupt missing");
    a_regs_at_release: assert property ($fell(chip_rst) |-> fen_q == '0 && srst_q == '0)
        else $error("registers not reset at release");
    a_soft_rst_write: assert property (wr && addr == cgu_pkg::SOFT_RST && !sys_rst |=> soft_rst == $past(wdata[15:0]))
        else $error("soft reset bits not written");
    a_lp_ranges: assert property (lp_mult >= 6'h01 && lp_mult <= 6'h20 && $onehot(lp_postdiv))
        else $error("low power pll setting out of range");
    a_hs_ranges: assert property (hs_prediv != '0 && hs_mult != '0 && hs_postdiv <= 5'h10)
        else $error("high speed pll setting out of range");
    a_switch_quiet: assert property (g_grp[6].sw_q |-> !grp_tick[6])
        else $error("group pulse during source switch");
    a_div_follows_src: assert property (div_tick[0] |-> $past(grp_tick[0]))
        else $error("divider pulse without source pulse");
    a_feed_reload: assert property (wr && addr == cgu_pkg::WDT_FEED && !sys_rst |=> wcnt_q == $past(wload_q))
        else $error("watchdog feed did not reload");

    c_wdt_reset: cover property (wdt_fire ##1 chip_rst);
    c_switch: cover property (g_grp[6].sw_q ##[1:20] !g_grp[6].sw_q);
    c_evt_clock: cover property (fevt_q[6] && evt_clk_on[6] && func_tick[6]);
endmodule : clock_gen_unit

// File: verilog/frac_div.sv
// Fractional rate divider: inc pulses out per mod pulses in
module frac_div (
    input wire logic clk,
    input wire logic rst,
    input wire logic src_tick,
    input wire logic [cgu_pkg::FRAC_W-1:0] inc,
    input wire logic [cgu_pkg::FRAC_W-1:0] mod,
    output logic out_tick
);
    localparam int FRAC_W = cgu_pkg::FRAC_W;
    logic [cgu_pkg::FRAC_W-1:0] acc_q;
    logic [cgu_pkg::FRAC_W-1:0] acc_d;
    logic tick_q;
    logic tick_d;
    logic [cgu_pkg::FRAC_W:0] sum;

    // Accumulate on each source pulse, emit on overflow
    always_comb begin
        sum = {1'b0, acc_q} + {1'b0, inc};
        acc_d = acc_q;
        tick_d = 1'b0;
        if (src_tick) begin
            if (mod == '0 || inc >= mod) begin
                tick_d = 1'b1; // Pass-through when unprogrammed
                acc_d = '0;
            end else if (sum >= {1'b0, mod}) begin
                tick_d = 1'b1;
                acc_d = FRAC_W'(sum - {1'b0, mod});
            end else begin
                acc_d = sum[cgu_pkg::FRAC_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign out_tick = tick_q;
endmodule : frac_div
